// >>> verilog/gpds_consts.vh
// Purpose: constants for the gpio port and drive strength block
// Assumes: 8-bit register port, word indices chosen locally
// Notes:   offsets are register indices on the plain register port
`ifndef GPDS_CONSTS_VH
`define GPDS_CONSTS_VH
`define GPDS_ADDR_W          4
`define GPDS_PORT_W          8
`define GPDS_OFF_PIN_FUNC    4'h0
`define GPDS_OFF_DIR         4'h1
`define GPDS_OFF_OUT_DATA    4'h2
`define GPDS_OFF_PIN_SET     4'h3
`define GPDS_OFF_CLEAR       4'h4
`define GPDS_OFF_SER_DRIVE   4'h5
`define GPDS_OFF_SPI_DRIVE   4'h6
`define GPDS_OFF_TMR_DRIVE   4'h7
`define GPDS_BIT_IRQ_DRV     6
`define GPDS_BIT_SER2_DRV    4
`define GPDS_BIT_SER1_DRV    2
`define GPDS_BIT_SER0_DRV    0
`define GPDS_BIT_SPI_DRV     0
`define GPDS_BIT_TMR_DRV     0
`define GPDS_SER_DRV_MASK    8'h55
`define GPDS_ONE_DRV_MASK    8'h01
`define GPDS_RST_PIN_FUNC    8'h00
`define GPDS_RST_DIR         8'h00
`define GPDS_RST_OUT_DATA    8'h00
`define GPDS_RST_DRIVE       8'h00
`endif

// >>> verilog/gpds_port.v
// Purpose: one 8-pin gpio port with pin assignment and drive strength control
// Assumes: single clock clk, async active-low resetn, pins synchronous to clk
// Notes:   no interrupt output; drive bits load from strap after reset release
//
// Overview of operation
// - drive bits reset to 0 if config high, else to data line 21
// - serial/irq bit 6 selects irq pin drive strength
// - serial/irq bit 4 selects third serial port drive
// - serial/irq bit 2 selects second serial port drive
// - serial/irq bit 0 selects first serial port drive
// - spi bit 0 selects drive for all spi pins
// - timer bit 0 selects drive for all timer pins
// - pins default to gpio except bus, address/data, chip selects; here pin assignment resets to 0, so all 8 pins start as gpio
// - pin assignment register picks primary function or gpio per pin
// - one direction bit per pin
// - output data held and driven on gpio outputs
// - output data read returns stored value
// - pin data read returns actual pin levels; here synchronised levels, with pins in primary function reading 0
// - set and clear registers modify output data bits
// - the port raises no interrupt
// - gpio inputs synchronised on rising clock edge
// - output data reaches pin right after write
// - every register except the three drive registers resets to a fixed value
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "gpds_consts.vh"
module gpds_port (
  input  wire                      clk,
  input  wire                      resetn,
  input  wire [`GPDS_ADDR_W-1:0]   reg_addr,
  input  wire [7:0]                reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [7:0]                reg_rdata,
  input  wire                      reset_config_sel_n,
  input  wire                      strap_data21,
  input  wire [`GPDS_PORT_W-1:0]   pin_in,
  output reg  [`GPDS_PORT_W-1:0]   pin_out,
  output reg  [`GPDS_PORT_W-1:0]   pin_oe,
  input  wire [`GPDS_PORT_W-1:0]   prim_out,
  input  wire [`GPDS_PORT_W-1:0]   prim_oe,
  output reg  [`GPDS_PORT_W-1:0]   prim_in,
  output reg                       irq_pin_drive_sel,
  output reg                       serial2_drive_sel,
  output reg                       serial1_drive_sel,
  output reg                       serial0_drive_sel,
  output reg                       spi_drive_sel,
  output reg                       timer_drive_sel
);
  reg [7:0] pin_func_r;
  reg [7:0] port_direction_reg;
  reg [7:0] port_output_data_reg;
  reg [7:0] out_data_nxt;
  reg [7:0] serial_irq_drive_ctrl;
  reg [7:0] spi_drive_ctrl;
  reg [7:0] timer_drive_ctrl;
  reg [7:0] pin_sync_r;
  reg       strap_done_r;
  reg [7:0] rdata_nxt;
  wire      wr_ser = reg_wr && (reg_addr == `GPDS_OFF_SER_DRIVE);
  wire      wr_spi = reg_wr && (reg_addr == `GPDS_OFF_SPI_DRIVE);
  wire      wr_tmr = reg_wr && (reg_addr == `GPDS_OFF_TMR_DRIVE);
  wire [7:0] strap_val = (!reset_config_sel_n && strap_data21) ? 8'hff : 8'h00;

  always @* begin
    out_data_nxt = port_output_data_reg;
    if (reg_wr) begin
      case (reg_addr)
        `GPDS_OFF_OUT_DATA: out_data_nxt = reg_wdata;
        `GPDS_OFF_PIN_SET:  out_data_nxt = port_output_data_reg | reg_wdata;
        `GPDS_OFF_CLEAR:    out_data_nxt = port_output_data_reg & reg_wdata;
        default:            out_data_nxt = port_output_data_reg;
      endcase
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_func_r           <= `GPDS_RST_PIN_FUNC;
      port_direction_reg   <= `GPDS_RST_DIR;
      port_output_data_reg <= `GPDS_RST_OUT_DATA;
    end else begin
      if (reg_wr && reg_addr == `GPDS_OFF_PIN_FUNC)
        pin_func_r <= reg_wdata;
      if (reg_wr && reg_addr == `GPDS_OFF_DIR)
        port_direction_reg <= reg_wdata;
      port_output_data_reg <= out_data_nxt;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_done_r          <= 1'b0;
      serial_irq_drive_ctrl <= `GPDS_RST_DRIVE;
      spi_drive_ctrl        <= `GPDS_RST_DRIVE;
      timer_drive_ctrl      <= `GPDS_RST_DRIVE;
    end else if (!strap_done_r) begin
      strap_done_r          <= 1'b1;
      serial_irq_drive_ctrl <= strap_val & `GPDS_SER_DRV_MASK;
      spi_drive_ctrl        <= strap_val & `GPDS_ONE_DRV_MASK;
      timer_drive_ctrl      <= strap_val & `GPDS_ONE_DRV_MASK;
    end else begin
      if (wr_ser)
        serial_irq_drive_ctrl <= reg_wdata & `GPDS_SER_DRV_MASK;
      if (wr_spi)
        spi_drive_ctrl <= reg_wdata & `GPDS_ONE_DRV_MASK;
      if (wr_tmr)
        timer_drive_ctrl <= reg_wdata & `GPDS_ONE_DRV_MASK;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_pin_drive_sel <= 1'b0;
      serial2_drive_sel <= 1'b0;
      serial1_drive_sel <= 1'b0;
      serial0_drive_sel <= 1'b0;
      spi_drive_sel     <= 1'b0;
      timer_drive_sel   <= 1'b0;
    end else begin
      irq_pin_drive_sel <= serial_irq_drive_ctrl[`GPDS_BIT_IRQ_DRV];
      serial2_drive_sel <= serial_irq_drive_ctrl[`GPDS_BIT_SER2_DRV];
      serial1_drive_sel <= serial_irq_drive_ctrl[`GPDS_BIT_SER1_DRV];
      serial0_drive_sel <= serial_irq_drive_ctrl[`GPDS_BIT_SER0_DRV];
      spi_drive_sel     <= spi_drive_ctrl[`GPDS_BIT_SPI_DRV];
      timer_drive_sel   <= timer_drive_ctrl[`GPDS_BIT_TMR_DRV];
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      pin_sync_r <= 8'h00;
    else
      pin_sync_r <= pin_in;
  end

  // pad muxing per pin
  genvar i;
  generate
    for (i = 0; i < `GPDS_PORT_W; i = i + 1) begin : g_pin
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          pin_out[i] <= 1'b0;
          pin_oe[i]  <= 1'b0;
          prim_in[i] <= 1'b0;
        end else if (pin_func_r[i]) begin
          pin_out[i] <= prim_out[i];
          pin_oe[i]  <= prim_oe[i];
          prim_in[i] <= pin_in[i];
        end else begin
          pin_out[i] <= out_data_nxt[i];
          pin_oe[i]  <= port_direction_reg[i];
          prim_in[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always @* begin
    case (reg_addr)
      `GPDS_OFF_PIN_FUNC:  rdata_nxt = pin_func_r;
      `GPDS_OFF_DIR:       rdata_nxt = port_direction_reg;
      `GPDS_OFF_OUT_DATA:  rdata_nxt = port_output_data_reg;
      `GPDS_OFF_PIN_SET:   rdata_nxt = pin_sync_r & ~pin_func_r;
      `GPDS_OFF_CLEAR:     rdata_nxt = 8'h00;
      `GPDS_OFF_SER_DRIVE: rdata_nxt = serial_irq_drive_ctrl;
      `GPDS_OFF_SPI_DRIVE: rdata_nxt = spi_drive_ctrl;
      `GPDS_OFF_TMR_DRIVE: rdata_nxt = timer_drive_ctrl;
      default:             rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
    else
      reg_rdata <= 8'h00;
  end
endmodule

// >>> dv/gpds_chk.sv
// Purpose: port checker for gpds_port
// Assumes: single clock, async low reset
// Notes: drive outputs lag their register by one edge
`timescale 1ns/1ps
module gpds_chk (
  input wire       clk, resetn, reg_wr, reg_rd, reset_config_sel_n, strap_data21,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata, reg_rdata, pin_out, pin_oe,
  input wire       irq_pin_drive_sel, serial2_drive_sel, serial1_drive_sel,
  input wire       serial0_drive_sel, spi_drive_sel, timer_drive_sel
);
  wire [7:0] ser = {1'b0, irq_pin_drive_sel, 1'b0, serial2_drive_sel,
                    1'b0, serial1_drive_sel, 1'b0, serial0_drive_sel};
  wire       s   = !reset_config_sel_n && strap_data21;
  wire [7:0] od  = pin_out & pin_oe;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_strap_load:
    assert property ($rose(resetn) |-> ##2 ser == ({8{s}} & 8'h55)
      && spi_drive_sel == s && timer_drive_sel == s) else $error("bad strap load");
  a_ser_drive:
    assert property (reg_wr && reg_addr == 4'h5 |-> ##2
      ser == ($past(reg_wdata, 2) & 8'h55)) else $error("bad serial drive");
  a_spi_drive:
    assert property (reg_wr && reg_addr == 4'h6 |-> ##2
      spi_drive_sel == $past(reg_wdata[0], 2)) else $error("bad spi drive");
  a_tmr_drive:
    assert property (reg_wr && reg_addr == 4'h7 |-> ##2
      timer_drive_sel == $past(reg_wdata[0], 2)) else $error("bad timer drive");
  a_out_pin:
    assert property (reg_wr && reg_addr == 4'h2 |=>
      od == ($past(reg_wdata) & pin_oe)) else $error("bad pin drive");
  a_set_bits:
    assert property (reg_wr && reg_addr == 4'h3 |=>
      od == (($past(pin_out) | $past(reg_wdata)) & pin_oe)) else $error("bad set");
  a_clr_bits:
    assert property (reg_wr && reg_addr == 4'h4 |=>
      od == ($past(pin_out) & $past(reg_wdata) & pin_oe)) else $error("bad clear");
  a_rd_stored:
    assert property (reg_rd && reg_addr == 4'h2 |=>
      (reg_rdata & pin_oe) == $past(od)) else $error("bad data read");
  cover property (reg_wr && reg_addr == 4'h5);
  cover property (reg_rd && reg_addr == 4'h3);
  cover property ($rose(resetn) && s);
endmodule
bind gpds_port gpds_chk u_chk (.*);

// >>> dv/gpds_pins.sv
// Purpose: board side of the port pins
// Assumes: no pull on the lines
// Notes: undriven lines follow a board level that the bench changes
`timescale 1ns/1ps
module gpds_pins (
  input  wire [7:0] pin_out, pin_oe, ext,
  output wire [7:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

// >>> dv/tb_top.sv
// Purpose: self-checking bench for gpds_port
// Assumes: pins stay gpio until the last test moves the low nibble to primary function
// Notes: register model kept in the bench
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic       clk = 0, resetn = 0, wr = 0, rd = 0, cfg_n = 0;
  logic [3:0] addr = 0, a;
  logic [7:0] wd = 0, ext = 0, po = 0, pe = 0, d, dir, od, ser, spi, tmr, fn;
  wire  [7:0] rdata, pin_out, pin_oe, pin_in, prim_in;
  int         err_count = 0, checks = 0, i, k;
  gpds_port dut (.clk(clk), .resetn(resetn), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .reset_config_sel_n(cfg_n),
    .strap_data21(1'b1), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .prim_out(po), .prim_oe(pe), .prim_in(prim_in), .irq_pin_drive_sel(),
    .serial2_drive_sel(), .serial1_drive_sel(), .serial0_drive_sel(),
    .spi_drive_sel(), .timer_drive_sel());
  gpds_pins board (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
  initial forever #12.5 clk = ~clk;
  task results;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task wrt(input [3:0] ad, input [7:0] dd);
    @(posedge clk); addr <= ad; wd <= dd; wr <= 1;
    @(posedge clk); wr <= 0;
    case (ad)
      0: fn = dd; 1: dir = dd; 2: od = dd; 3: od = od | dd; 4: od = od & dd;
      5: ser = dd & 8'h55; 6: spi = dd & 1; 7: tmr = dd & 1;
      default: ;
    endcase
  endtask
  function [7:0] expv(input [3:0] ad);
    case (ad)
      0: expv = fn; 1: expv = dir; 2: expv = od;
      3: expv = ((dir & od) | (~dir & ext)) & ~fn;
      5: expv = ser; 6: expv = spi; 7: expv = tmr; default: expv = 0;
    endcase
  endfunction
  task rdc(input [3:0] ad);
    @(posedge clk); addr <= ad; rd <= 1;
    @(posedge clk); rd <= 0;
    @(negedge clk); `CHK(rdata, expv(ad))
  endtask
  task rst(input c);
    @(posedge clk); resetn <= 0; cfg_n <= c;
    repeat (5) @(posedge clk); resetn <= 1;
    repeat (2) @(posedge clk);
    fn = 0; dir = 0; od = 0; ser = {8{!c}} & 8'h55; spi = !c; tmr = !c;
  endtask
  initial begin
    void'($urandom(63607));
    for (i = 1; i >= 0; i--) begin
      rst(i);
      for (k = 0; k < 16; k++) rdc(k);
    end
    wrt(5, 8'h55); rdc(5);
    wrt(1, 8'hFF); wrt(2, 8'hA5); wrt(3, 8'h0A); wrt(4, 8'hF0); rdc(2);
    `CHK(pin_out, 8'hA0)
    for (i = 0; i < 60; i++) begin
      ext <= 8'($urandom); po <= 8'($urandom); pe <= 8'($urandom);
      a = 4'($urandom_range(1, 15)); d = 8'($urandom);
      if (a > 4 && a < 8) d = d & ((a == 5) ? 8'h55 : 8'h01);
      wrt(a, d); rdc(a); rdc(3);
      `CHK(pin_oe, dir)
      `CHK(pin_out & dir, od & dir)
    end
    // low nibble to primary function
    wrt(0, 8'h0F); rdc(0);
    repeat (2) @(negedge clk);
    `CHK(pin_out & 8'h0F, po & 8'h0F)
    `CHK(pin_oe & 8'h0F, pe & 8'h0F)
    `CHK(prim_in, pin_in & 8'h0F)
    rdc(3);
    results;
  end
  initial begin
    #100000; err_count++; results;
  end
endmodule
